// ===== rtl/oprs_pkg.sv
// Purpose: Shared constants for the output pin remap select block
// Assumes: 32-bit register words at byte addresses, 4-bit selectors
// Notes: Pin index order follows the register offset order
package oprs_pkg;

	localparam int NPIN = 17;
	localparam int SEL_W = 4;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int NSRC = 10;
	localparam int IDX_W = 5;

	typedef logic [SEL_W-1:0] oprs_sel_t;
	typedef logic [NPIN-1:0] oprs_pins_t;

	localparam oprs_sel_t SEL_RESET = 4'h0;
	localparam oprs_sel_t SEL_NC = 4'h0;

	// First group codes
	localparam oprs_sel_t G1_UART3_TX = 4'h1;
	localparam oprs_sel_t G1_UART4_RTS = 4'h2;
	localparam oprs_sel_t G1_SPI2_OUT = 4'h6;
	localparam oprs_sel_t G1_COMPARE3 = 4'hb;
	localparam oprs_sel_t G1_CMP2 = 4'hd;

	// Second group codes
	localparam oprs_sel_t G2_UART2_TX = 4'h1;
	localparam oprs_sel_t G2_UART1_TX = 4'h3;
	localparam oprs_sel_t G2_UART5_RTS = 4'h4;
	localparam oprs_sel_t G2_SPI2_OUT = 4'h6;
	localparam oprs_sel_t G2_SPI1_OUT = 4'h8;
	localparam oprs_sel_t G2_COMPARE4 = 4'hb;

	// Bit positions of the peripheral source vector
	localparam int SRC_UART3_TX = 0;
	localparam int SRC_UART4_RTS = 1;
	localparam int SRC_SPI2_OUT = 2;
	localparam int SRC_COMPARE3 = 3;
	localparam int SRC_CMP2 = 4;
	localparam int SRC_UART2_TX = 5;
	localparam int SRC_UART1_TX = 6;
	localparam int SRC_UART5_RTS = 7;
	localparam int SRC_SPI1_OUT = 8;
	localparam int SRC_COMPARE4 = 9;

	// Pin index of a few registers named by the checks
	localparam int PIN_A14 = 0;
	localparam int PIN_B0 = 2;
	localparam int PIN_B1 = 3;
	localparam int PIN_B3 = 5;
	localparam int PIN_B9 = 10;

	// A14 A15 B0 B1 B2 B3 B5 B6 B7 B8 B9 B10 B14 B15 C1 C2 C3
	localparam logic [ADDR_W-1:0] REG_OFS [NPIN] = '{
		16'hfb38, 16'hfb3c, 16'hfb40, 16'hfb44, 16'hfb48, 16'hfb4c,
		16'hfb54, 16'hfb58, 16'hfb5c, 16'hfb60, 16'hfb64, 16'hfb68,
		16'hfb78, 16'hfb7c, 16'hfb84, 16'hfb88, 16'hfb8c};

	// Set bit: pin uses the second code table
	localparam oprs_pins_t GROUP2_MASK = 17'h1213a;
	// Set bit: register exists only on the large package
	localparam oprs_pins_t PIN100_ONLY_MASK = 17'h1c003;

endpackage

// ===== rtl/oprs_src_if.sv
// Purpose: Carries the peripheral output signals to the pin decoders
// Assumes: All sources run on the block clock
// Notes: Bit positions are the SRC_ constants of the package
interface oprs_src_if;
	logic [oprs_pkg::NSRC-1:0] sig;
	modport drv (output sig);
	modport rcv (input sig);
endinterface

// ===== rtl/oprs_addr_dec.sv
// Purpose: Decodes a bus address onto one select register
// Assumes: Exact byte address match, word aligned offsets
// Notes: Absent registers never hit, so they read zero and ignore writes
module oprs_addr_dec (
	input wire logic [oprs_pkg::ADDR_W-1:0] i_addr, // Bus address
	input wire oprs_pkg::oprs_pins_t i_present, // Registers that exist
	output oprs_pkg::oprs_pins_t o_hit, // One-hot register hit
	output logic [oprs_pkg::IDX_W-1:0] o_idx, // Index of the hit
	output logic o_any // Address is mapped
);

	genvar g;
	generate
		for (g = 0; g < oprs_pkg::NPIN; g++)
		begin : g_hit
			assign o_hit[g] = i_present[g] &&
				(i_addr == oprs_pkg::REG_OFS[g]);
		end
	endgenerate

	always_comb
	begin
		o_idx = '0;
		for (int k = 0; k < oprs_pkg::NPIN; k++)
		begin
			if (o_hit[k])
			begin
				o_idx = oprs_pkg::IDX_W'(k);
			end
		end
	end

	assign o_any = |o_hit;

endmodule

// ===== rtl/oprs_decode.sv
// Purpose: Turns one pin selector into a routed peripheral signal
// Assumes: Selector already held in a register
// Notes: Reserved and no-connect codes release the pin to the latch
module oprs_decode (
	input wire oprs_pkg::oprs_sel_t i_sel, // Pin selector
	input wire logic i_group2, // Pin uses second table
	input wire logic i_u5_ok, // Large package variant
	oprs_src_if.rcv src, // Peripheral outputs
	output logic o_route_en, // Peripheral owns pin
	output logic o_route_val // Routed peripheral level
);

	always_comb
	begin
		o_route_en = 1'b0;
		o_route_val = 1'b0;
		if (!i_group2)
		begin
			unique case (i_sel)
				oprs_pkg::G1_UART3_TX:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_UART3_TX];
				end
				oprs_pkg::G1_UART4_RTS:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_UART4_RTS];
				end
				oprs_pkg::G1_SPI2_OUT:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_SPI2_OUT];
				end
				oprs_pkg::G1_COMPARE3:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_COMPARE3];
				end
				oprs_pkg::G1_CMP2:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_CMP2];
				end
				// No connect and reserved codes leave the pin alone
				default:
				begin
					o_route_en = 1'b0;
				end
			endcase
		end
		else
		begin
			unique case (i_sel)
				oprs_pkg::G2_UART2_TX:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_UART2_TX];
				end
				oprs_pkg::G2_UART1_TX:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_UART1_TX];
				end
				oprs_pkg::G2_UART5_RTS:
				begin
					// Source missing on the small package
					o_route_en = i_u5_ok;
					o_route_val = i_u5_ok &&
						src.sig[oprs_pkg::SRC_UART5_RTS];
				end
				oprs_pkg::G2_SPI2_OUT:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_SPI2_OUT];
				end
				oprs_pkg::G2_SPI1_OUT:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_SPI1_OUT];
				end
				oprs_pkg::G2_COMPARE4:
				begin
					o_route_en = 1'b1;
					o_route_val = src.sig[oprs_pkg::SRC_COMPARE4];
				end
				default:
				begin
					o_route_en = 1'b0;
				end
			endcase
		end
	end

endmodule

// ===== rtl/oprs_top.sv
// Purpose: Output pin remap select, registers plus per-pin routing
// Assumes: Peripheral sources and port latches on the same clock
// Notes: Pin outputs are registered, one cycle behind the selectors
//
// Decided for this implementation: the plain strobed port.
module oprs_top #(
	parameter bit PIN100 = 1'b1 // Large package variant
) (
	input wire logic i_clk, // Block clock, 125 MHz
	input wire logic i_clk_en, // Freezes all state when low
	input wire logic i_sys_rst, // Async reset, active high
	input wire logic [oprs_pkg::ADDR_W-1:0] i_addr, // Register address
	input wire logic [oprs_pkg::DATA_W-1:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [oprs_pkg::DATA_W-1:0] o_rdata, // Read data, next cycle
	input wire logic i_uart3_transmit, // UART3 transmit
	input wire logic i_uart4_request_to_send, // UART4 request to send
	input wire logic i_spi2_serial_out, // SPI2 serial out
	input wire logic i_output_compare_3, // Output compare 3
	input wire logic i_comparator_2_output, // Comparator 2 output
	input wire logic i_uart2_transmit, // UART2 transmit
	input wire logic i_uart1_transmit, // UART1 transmit
	input wire logic i_uart5_request_to_send, // UART5 request to send
	input wire logic i_spi1_serial_out, // SPI1 serial out
	input wire logic i_output_compare_4, // Output compare 4
	input wire oprs_pkg::oprs_pins_t i_port_latch, // Ordinary port levels
	output oprs_pkg::oprs_pins_t o_pin_out, // Level per remappable pin
	output oprs_pkg::oprs_pins_t o_pin_remap // Pin owned by peripheral
);

	localparam int PAD_W = oprs_pkg::DATA_W - oprs_pkg::SEL_W;

	oprs_src_if src_bus ();

	oprs_pkg::oprs_pins_t present;
	oprs_pkg::oprs_pins_t hit;
	oprs_pkg::oprs_pins_t route_en;
	oprs_pkg::oprs_pins_t route_val;
	logic [oprs_pkg::IDX_W-1:0] idx;
	logic hit_any;
	oprs_pkg::oprs_sel_t sel_q [oprs_pkg::NPIN];
	oprs_pkg::oprs_sel_t sel_d [oprs_pkg::NPIN];
	logic [oprs_pkg::DATA_W-1:0] rdata_q;
	logic [oprs_pkg::DATA_W-1:0] rdata_d;
	oprs_pkg::oprs_pins_t pin_q;
	oprs_pkg::oprs_pins_t pin_d;
	oprs_pkg::oprs_pins_t remap_q;
	oprs_pkg::oprs_pins_t remap_d;

	// Registers of the extra pins are built but masked out of decode and routing
	assign present = PIN100 ? '1 : ~oprs_pkg::PIN100_ONLY_MASK;

	// One process drives the whole source vector
	always_comb
	begin
		src_bus.sig[oprs_pkg::SRC_UART3_TX] = i_uart3_transmit;
		src_bus.sig[oprs_pkg::SRC_UART4_RTS] = i_uart4_request_to_send;
		src_bus.sig[oprs_pkg::SRC_SPI2_OUT] = i_spi2_serial_out;
		src_bus.sig[oprs_pkg::SRC_COMPARE3] = i_output_compare_3;
		src_bus.sig[oprs_pkg::SRC_CMP2] = i_comparator_2_output;
		src_bus.sig[oprs_pkg::SRC_UART2_TX] = i_uart2_transmit;
		src_bus.sig[oprs_pkg::SRC_UART1_TX] = i_uart1_transmit;
		src_bus.sig[oprs_pkg::SRC_UART5_RTS] = i_uart5_request_to_send;
		src_bus.sig[oprs_pkg::SRC_SPI1_OUT] = i_spi1_serial_out;
		src_bus.sig[oprs_pkg::SRC_COMPARE4] = i_output_compare_4;
	end

	oprs_addr_dec u_addr_dec (
		.i_addr (i_addr),
		.i_present (present),
		.o_hit (hit),
		.o_idx (idx),
		.o_any (hit_any)
	);

	// Selector storage
	always_comb
	begin
		for (int k = 0; k < oprs_pkg::NPIN; k++)
		begin
			sel_d[k] = sel_q[k];
			if (i_wr && hit[k])
			begin
				// Upper data bits are dropped, nothing to store them
				sel_d[k] = i_wdata[oprs_pkg::SEL_W-1:0];
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			for (int k = 0; k < oprs_pkg::NPIN; k++)
			begin
				sel_q[k] <= oprs_pkg::SEL_RESET;
			end
		end
		else if (i_clk_en)
		begin
			sel_q <= sel_d;
		end
	end

	// Read path; an unmapped address, such as one for port F
	// pins 6 or 7 which have no selector, answers zero
	always_comb
	begin
		rdata_d = '0;
		if (i_rd && hit_any)
		begin
			rdata_d = {{PAD_W{1'b0}}, sel_q[idx]};
		end
		else
		begin
			rdata_d = '0;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			rdata_q <= '0;
		end
		else if (i_clk_en)
		begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// Per-pin routing
	genvar g;
	generate
		for (g = 0; g < oprs_pkg::NPIN; g++)
		begin : g_pin
			oprs_decode u_decode (
				.i_sel (sel_q[g]),
				.i_group2 (oprs_pkg::GROUP2_MASK[g]),
				.i_u5_ok (PIN100),
				.src (src_bus.rcv),
				.o_route_en (route_en[g]),
				.o_route_val (route_val[g])
			);
		end
	endgenerate

	always_comb
	begin
		remap_d = route_en & present;
		// Falling back to the latch keeps a released pin quiet
		pin_d = (route_val & remap_d) | (i_port_latch & ~remap_d);
	end

	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pin_q <= '0;
			remap_q <= '0;
		end
		else if (i_clk_en)
		begin
			pin_q <= pin_d;
			remap_q <= remap_d;
		end
	end

	assign o_pin_out = pin_q;
	assign o_pin_remap = remap_q;

	// Checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_write;
		i_clk_en && i_wr && hit_any;
	endsequence

	sequence s_read_same;
		i_clk_en && i_rd && (i_addr == $past(i_addr));
	endsequence

	a_reserved_bits_zero: assert property (
		o_rdata[oprs_pkg::DATA_W-1:oprs_pkg::SEL_W] == '0)
		else $error("Unimplemented read bits are not zero");

	a_write_read_back: assert property (
		s_write ##1 s_read_same |=>
		o_rdata[oprs_pkg::SEL_W-1:0] ==
		$past(i_wdata[oprs_pkg::SEL_W-1:0], 2))
		else $error("Selector read back differs from write");

	a_reset_clears_sel: assert property (
		$past(i_sys_rst) |-> (sel_q[oprs_pkg::PIN_B0] ==
		oprs_pkg::SEL_RESET && o_pin_remap == '0))
		else $error("Selector not cleared by reset");

	a_g1_uart3_route: assert property (
		(i_clk_en && present[oprs_pkg::PIN_A14] &&
		sel_q[oprs_pkg::PIN_A14] == oprs_pkg::G1_UART3_TX) |=>
		(o_pin_remap[oprs_pkg::PIN_A14] &&
		o_pin_out[oprs_pkg::PIN_A14] == $past(i_uart3_transmit)))
		else $error("UART3 transmit not routed on first group");

	a_g1_compare3_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B9] == oprs_pkg::G1_COMPARE3)
		|=> (o_pin_remap[oprs_pkg::PIN_B9] &&
		o_pin_out[oprs_pkg::PIN_B9] == $past(i_output_compare_3)))
		else $error("Output compare 3 not routed");

	a_g2_uart1_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B1] == oprs_pkg::G2_UART1_TX)
		|=> (o_pin_remap[oprs_pkg::PIN_B1] &&
		o_pin_out[oprs_pkg::PIN_B1] == $past(i_uart1_transmit)))
		else $error("UART1 transmit not routed on second group");

	a_g2_spi1_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B3] == oprs_pkg::G2_SPI1_OUT)
		|=> (o_pin_remap[oprs_pkg::PIN_B3] &&
		o_pin_out[oprs_pkg::PIN_B3] == $past(i_spi1_serial_out)))
		else $error("SPI1 serial out not routed");

	a_absent_pins_idle: assert property (
		(o_pin_remap & ~present) == '0)
		else $error("Absent pin taken by a peripheral");

	a_u5_variant_only: assert property (
		(i_clk_en && !PIN100 &&
		sel_q[oprs_pkg::PIN_B1] == oprs_pkg::G2_UART5_RTS) |=>
		!o_pin_remap[oprs_pkg::PIN_B1])
		else $error("UART5 request to send routed on small package");

	a_unmapped_zero: assert property (
		(i_clk_en && i_rd && !hit_any) |=> o_rdata == '0)
		else $error("Unmapped read returned data");

	a_rdata_one_cycle: assert property (
		(i_clk_en && !i_rd) |=> o_rdata == '0)
		else $error("Read data outside its cycle");

	// Reset falls on an edge that still clears the pins, so skip it
	a_latch_fallback: assert property (
		(!i_sys_rst && i_clk_en && !route_en[oprs_pkg::PIN_B0]) |=>
		(!o_pin_remap[oprs_pkg::PIN_B0] &&
		o_pin_out[oprs_pkg::PIN_B0] ==
		$past(i_port_latch[oprs_pkg::PIN_B0])))
		else $error("Released pin does not follow its latch");

	a_g1_uart4_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B0] == oprs_pkg::G1_UART4_RTS)
		|=> (o_pin_remap[oprs_pkg::PIN_B0] &&
		o_pin_out[oprs_pkg::PIN_B0] == $past(i_uart4_request_to_send)))
		else $error("UART4 request to send not routed");

	a_g1_spi2_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B0] == oprs_pkg::G1_SPI2_OUT)
		|=> (o_pin_remap[oprs_pkg::PIN_B0] &&
		o_pin_out[oprs_pkg::PIN_B0] == $past(i_spi2_serial_out)))
		else $error("SPI2 serial out not routed on first group");

	a_g1_cmp2_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B0] == oprs_pkg::G1_CMP2)
		|=> (o_pin_remap[oprs_pkg::PIN_B0] &&
		o_pin_out[oprs_pkg::PIN_B0] == $past(i_comparator_2_output)))
		else $error("Comparator 2 output not routed");

	a_g2_uart2_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B1] == oprs_pkg::G2_UART2_TX)
		|=> (o_pin_remap[oprs_pkg::PIN_B1] &&
		o_pin_out[oprs_pkg::PIN_B1] == $past(i_uart2_transmit)))
		else $error("UART2 transmit not routed");

	a_g2_uart5_route: assert property (
		(i_clk_en && PIN100 &&
		sel_q[oprs_pkg::PIN_B1] == oprs_pkg::G2_UART5_RTS)
		|=> (o_pin_remap[oprs_pkg::PIN_B1] &&
		o_pin_out[oprs_pkg::PIN_B1] == $past(i_uart5_request_to_send)))
		else $error("UART5 request to send not routed on large package");

	a_g2_spi2_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B3] == oprs_pkg::G2_SPI2_OUT)
		|=> (o_pin_remap[oprs_pkg::PIN_B3] &&
		o_pin_out[oprs_pkg::PIN_B3] == $past(i_spi2_serial_out)))
		else $error("SPI2 serial out not routed on second group");

	a_g2_compare4_route: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B3] == oprs_pkg::G2_COMPARE4)
		|=> (o_pin_remap[oprs_pkg::PIN_B3] &&
		o_pin_out[oprs_pkg::PIN_B3] == $past(i_output_compare_4)))
		else $error("Output compare 4 not routed");

	// Code 1000 is a second table code but reserved in the first
	a_g1_reserved_idle: assert property (
		(i_clk_en && sel_q[oprs_pkg::PIN_B0] == oprs_pkg::G2_SPI1_OUT)
		|=> (!o_pin_remap[oprs_pkg::PIN_B0] &&
		o_pin_out[oprs_pkg::PIN_B0] ==
		$past(i_port_latch[oprs_pkg::PIN_B0])))
		else $error("Reserved code took a first group pin");

	a_g2_nc_idle: assert property (
		(!i_sys_rst && i_clk_en &&
		sel_q[oprs_pkg::PIN_B1] == oprs_pkg::SEL_NC)
		|=> (!o_pin_remap[oprs_pkg::PIN_B1] &&
		o_pin_out[oprs_pkg::PIN_B1] ==
		$past(i_port_latch[oprs_pkg::PIN_B1])))
		else $error("No connect code took a second group pin");

	a_absent_read_zero: assert property (
		(i_clk_en && !PIN100 && i_rd &&
		i_addr == oprs_pkg::REG_OFS[oprs_pkg::PIN_A14]) |=> o_rdata == '0)
		else $error("Absent register returned data");

	a_freeze_holds: assert property (
		!i_clk_en |=> $stable(o_pin_out) && $stable(o_rdata))
		else $error("State moved while clock enable low");

endmodule

// ===== bench/oprs_periph_model.sv
// Purpose: Stand-in for the peripheral outputs and the port latches
// Assumes: Same clock as the remap block, no synchronisers
// Notes: Levels change every cycle so a stale route cannot pass
module oprs_periph_model (
	input wire logic i_clk, // Block clock
	input wire logic i_sys_rst, // Async reset, active high
	output logic [9:0] o_src, // Peripheral output levels
	output oprs_pkg::oprs_pins_t o_latch // Port latch levels
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] st_q;
	always_ff @(posedge i_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			st_q <= 32'h1234abcd;
		else
			st_q <= {st_q[30:0], st_q[31] ^ st_q[21] ^ st_q[1] ^ st_q[0]};
	end
	// Mixed taps so latch and source bits are not simple shifts
	assign o_src = st_q[9:0] ^ st_q[31:22];
	assign o_latch = st_q[31:15] ^ st_q[16:0];
endmodule

// ===== bench/output_pin_remap_select_tb_top.sv
// Purpose: Self-checking bench for the output pin remap select block
// Assumes: Both package sizes built side by side on one bus
// Notes: A cycle model predicts read data and pins at every negedge
module output_pin_remap_select_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_clk_en, i_sys_rst, i_wr, i_rd, stall;
	logic [oprs_pkg::ADDR_W-1:0] i_addr;
	logic [oprs_pkg::DATA_W-1:0] i_wdata;
	logic [9:0] src;
	oprs_pkg::oprs_pins_t latch;
	logic [31:0] rdata [2];
	oprs_pkg::oprs_pins_t pin_out [2], pin_rm [2], exp_out [2], exp_rm [2];
	logic [31:0] exp_rd [2];
	int msel [2][17];
	int fail_count, samples_checked;
	// Source index per code, -1 routes nothing
	localparam int G1 [16] = '{-1, 0, 1, -1, -1, -1, 2, -1,
		-1, -1, -1, 3, -1, 4, -1, -1};
	localparam int G2 [16] = '{-1, 5, -1, 6, 7, -1, 2, -1,
		8, -1, -1, 9, -1, -1, -1, -1};

	oprs_periph_model u_periph (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.o_src(src), .o_latch(latch));

	for (genvar v = 0; v < 2; v++)
	begin : g_v
		oprs_top #(.PIN100(v == 1)) DUT (.i_clk(i_clk),
			.i_clk_en(i_clk_en), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
			.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata[v]),
			.i_uart3_transmit(src[0]), .i_uart4_request_to_send(src[1]),
			.i_spi2_serial_out(src[2]), .i_output_compare_3(src[3]),
			.i_comparator_2_output(src[4]), .i_uart2_transmit(src[5]),
			.i_uart1_transmit(src[6]), .i_uart5_request_to_send(src[7]),
			.i_spi1_serial_out(src[8]), .i_output_compare_4(src[9]),
			.i_port_latch(latch), .o_pin_out(pin_out[v]),
			.o_pin_remap(pin_rm[v]));
	end

	function automatic int pin_idx(logic [15:0] a, int v);
		for (int p = 0; p < 17; p++)
			if (a == oprs_pkg::REG_OFS[p] &&
				(v == 1 || !oprs_pkg::PIN100_ONLY_MASK[p]))
				return p;
		return -1;
	endfunction

	function automatic int src_of(int p, int s, int v);
		if (!oprs_pkg::GROUP2_MASK[p])
			return G1[s];
		if (s == 4 && v == 0)
			return -1;
		return G2[s];
	endfunction

	task automatic chk(string name, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic op(int k, logic [15:0] a, logic [31:0] d);
		@(posedge i_clk);
		i_wr <= k == 1;
		i_rd <= k == 2;
		i_addr <= a;
		i_wdata <= d;
		i_clk_en <= stall ? $urandom_range(0, 3) != 0 : 1'b1;
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(negedge i_clk)
	begin
		int p, s;
		for (int v = 0; v < 2; v++)
		begin
			if (!i_sys_rst)
			begin
				chk("rdata", exp_rd[v], rdata[v]);
				chk("pin_out", 32'(exp_out[v]), 32'(pin_out[v]));
				chk("pin_remap", 32'(exp_rm[v]), 32'(pin_rm[v]));
			end
			if (i_sys_rst)
			begin
				exp_rd[v] = '0;
				exp_out[v] = '0;
				exp_rm[v] = '0;
				msel[v] = '{default: 0};
			end
			else if (i_clk_en)
			begin
				p = pin_idx(i_addr, v);
				exp_rd[v] = (i_rd && p >= 0) ? 32'(msel[v][p]) : '0;
				for (int q = 0; q < 17; q++)
				begin
					s = src_of(q, msel[v][q], v);
					exp_rm[v][q] = s >= 0;
					exp_out[v][q] = s >= 0 ? src[s] : latch[q];
				end
				if (i_wr && p >= 0)
					msel[v][p] = int'(i_wdata[3:0]);
			end
		end
	end

	initial
	begin
		i_clk = 0;
		forever #4 i_clk = ~i_clk;
	end

	initial
	begin
		repeat (20000) @(posedge i_clk);
		fail_count++;
		print_verdict();
	end

	initial
	begin
		i_clk_en = 1;
		i_sys_rst = 1;
		i_wr = 0;
		i_rd = 0;
		i_addr = '0;
		i_wdata = '0;
		stall = 0;
		fail_count = 0;
		samples_checked = 0;
		void'($urandom(32'ha253));
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 0;
		for (int p = 0; p < 17; p++)
			op(2, oprs_pkg::REG_OFS[p], '0);
		op(2, 16'hfb50, '0);
		op(2, 16'hfb3a, '0);
		$display("test reset_values done");
		// Every code on every pin, junk in the unused upper bits
		for (int p = 0; p < 17; p++)
			for (int s = 0; s < 16; s++)
			begin
				op(1, oprs_pkg::REG_OFS[p], ($urandom() & 32'hfffffff0) | s);
				op(0, 16'h0000, $urandom());
				op(2, oprs_pkg::REG_OFS[p], $urandom());
				op(0, 16'h0000, $urandom());
			end
		$display("test all_codes done");
		// Back to back traffic, stalls and unmapped holes
		stall = 1;
		repeat (600)
			op($urandom_range(0, 2), 16'hfb30 + 16'($urandom_range(0, 24) * 4),
				$urandom());
		stall = 0;
		$display("test random_traffic done");
		op(0, 16'h0000, '0);
		i_sys_rst <= 1;
		op(0, 16'h0000, '0);
		op(0, 16'h0000, '0);
		i_sys_rst <= 0;
		for (int p = 0; p < 17; p++)
			op(2, oprs_pkg::REG_OFS[p], '0);
		op(0, 16'h0000, '0);
		op(0, 16'h0000, '0);
		$display("test mid_reset done");
		print_verdict();
	end
endmodule
